// *** common/cpg_pkg.sv ***
// Shared constants and types for the camera parallel input and output selection block
`default_nettype none
package cpg_pkg;
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned PIX_W         = 12;
  localparam int unsigned NGPO          = 4;

  // Register offsets
  localparam logic [7:0]  REG_EDGE      = 8'h03;
  localparam logic [7:0]  REG_PAYLOAD   = 8'h05;
  localparam logic [7:0]  REG_GPO_CTRL  = 8'h0D;
  localparam logic [7:0]  REG_STATUS    = 8'h0E;
  localparam logic [7:0]  REG_PIX_LO    = 8'h0F;
  localparam logic [7:0]  REG_PIX_HI    = 8'h10;

  // Field positions
  localparam int unsigned EDGE_BIT      = 0;
  localparam int unsigned MODE12_BIT    = 0;
  localparam int unsigned GPO_SEL_LSB   = 0;
  localparam int unsigned GPO_VAL_LSB   = 4;
  localparam int unsigned ST_OSC_BIT    = 0;
  localparam int unsigned ST_VIOL_BIT   = 1;
  localparam int unsigned ST_ALIVE_BIT  = 2;
  localparam int unsigned ST_PD_BIT     = 3;
  localparam int unsigned HI_LS_BIT     = 4;
  localparam int unsigned HI_FS_BIT     = 5;
  localparam int unsigned GPO_CLK_OUT   = 2;
  localparam int unsigned GPO_CLK_IN    = 3;

  // Reset values
  localparam logic        EDGE_RST      = 1'b1;
  localparam logic        MODE12_RST    = 1'b0;
  localparam logic [3:0]  GPO_SEL_RST   = 4'h0;
  localparam logic [3:0]  GPO_VAL_RST   = 4'h0;

  // Ten-bit payload: lowest ten inputs only
  localparam int unsigned NARROW_W      = 10;
  localparam logic [11:0] NARROW_MASK   = 12'h3FF;
  // Least pixel clock cycles between two sync changes in ten-bit mode
  localparam int unsigned SYNC_GAP      = 10;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned ALIVE_NS      = 1000;
  localparam int unsigned ALIVE_CYC     = ALIVE_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic             frame_sync;
    logic             line_sync;
    logic [PIX_W-1:0] data;
  } cpg_pixel_s;
endpackage
`default_nettype wire

// *** rtl/cpg_sync2.sv ***
// Two-stage synchroniser for signals arriving from pins
`default_nettype none
module cpg_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else if (ce_i) begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end

  assign q_o = sync_r;
endmodule
`default_nettype wire

// *** rtl/cpg_top.sv ***
// Parallel pixel capture front end and general-purpose output selection
//
// How it works
// - Ten-bit mode takes only pixel inputs 0..9; upper two are unused.
// - Twelve-bit mode captures pixel inputs 0..11 on every active pixel edge.
// - Twelve-bit mode carries line and frame sync raw, unrestricted.
// - Register 3 bit 0 selects which pixel clock edge samples the inputs.
// - Outputs 0 and 1 forward remote pin level or a local register bit.
// - Output 2 forwards remote pin or local bit, or drives clock in oscillator mode.
// - Output 3 forwards remote pin or local bit, or is oscillator clock input.
// - Power-down low stops clocking and returns all control registers to defaults.
// - Strapped mode chooses imager pixel clock or external oscillator as timing.
//
// The address map and the address-and-strobe port were chosen for this implementation.
`default_nettype none
module cpg_top
  import cpg_pkg::*;
#(
  parameter int unsigned OSCILLATOR_CLOCK_OUTPUT_HALF = 4
) (
  input  wire logic              sys_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              ce_i,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_we_i,
  input  wire logic              reg_re_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  // Imager pins
  input  wire logic              pixel_clk_i,
  input  wire logic [PIX_W-1:0]  pixel_data_i,
  input  wire logic              line_sync_i,
  input  wire logic              frame_sync_i,
  // Device pins
  input  wire logic              power_down_low_active_i,
  input  wire logic              osc_mode_strap_i,
  // Remote deserializer pin levels, same clock domain
  input  wire logic [NGPO-1:0]   remote_pin_i,
  // Forwarded output pins; pin 3 is two-way
  output logic      [NGPO-1:0]   forwarded_output_pin_o,
  output logic      [NGPO-1:0]   forwarded_output_pin_oe_o,
  input  wire logic              forwarded_output_pin3_i,
  // Captured pixel stream
  output cpg_pixel_s             pixel_o,
  output logic                   pixel_valid_o
);
  localparam int unsigned CNT_W = 8;

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v,
                                               input logic [CNT_W-1:0] lim);
    sat_inc = (v >= lim) ? lim : v + 8'h01;
  endfunction

  // Pin synchronisation
  cpg_pixel_s pin_px;
  cpg_pixel_s px_s;
  logic       pclk_s;
  logic       pd_n_s;
  logic       strap_s;
  logic       oscin_s;
  logic       pclk_d_r;
  logic       oscin_d_r;

  assign pin_px = '{frame_sync: frame_sync_i, line_sync: line_sync_i, data: pixel_data_i};

  cpg_sync2 #(.W(PIX_W + 6)) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .d_i       ({pin_px, pixel_clk_i, power_down_low_active_i, osc_mode_strap_i,
                 forwarded_output_pin3_i}),
    .q_o       ({px_s, pclk_s, pd_n_s, strap_s, oscin_s})
  );

  // Control registers
  logic       edge_rise_r;
  logic       mode12_r;
  logic [3:0] gpo_sel_r;
  logic [3:0] gpo_val_r;
  logic       viol_r;
  logic       osc_mode_r;
  logic       strap_taken_r;

  wire powered   = pd_n_s;
  wire wr_edge   = reg_we_i && (reg_addr_i == REG_EDGE);
  wire wr_mode   = reg_we_i && (reg_addr_i == REG_PAYLOAD);
  wire wr_gpo    = reg_we_i && (reg_addr_i == REG_GPO_CTRL);
  wire wr_status = reg_we_i && (reg_addr_i == REG_STATUS);

  // Strap is caught once after reset release, not under reset
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      osc_mode_r    <= 1'b0;
      strap_taken_r <= 1'b0;
    end else if (ce_i && !strap_taken_r && powered) begin
      osc_mode_r    <= strap_s;
      strap_taken_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || !powered) begin
      edge_rise_r <= EDGE_RST;
      mode12_r    <= MODE12_RST;
      gpo_sel_r   <= GPO_SEL_RST;
      gpo_val_r   <= GPO_VAL_RST;
    end else if (ce_i) begin
      if (wr_edge) begin
        edge_rise_r <= reg_wdata_i[EDGE_BIT];
      end
      if (wr_mode) begin
        mode12_r <= reg_wdata_i[MODE12_BIT];
      end
      if (wr_gpo) begin
        gpo_sel_r <= reg_wdata_i[GPO_SEL_LSB +: NGPO];
        gpo_val_r <= reg_wdata_i[GPO_VAL_LSB +: NGPO];
      end
    end
  end

  // Pixel clock edge detection on the synchronised copy
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pclk_d_r  <= 1'b0;
      oscin_d_r <= 1'b0;
    end else if (ce_i) begin
      pclk_d_r  <= pclk_s;
      oscin_d_r <= oscin_s;
    end
  end

  wire pclk_rise  = pclk_s && !pclk_d_r;
  wire pclk_fall  = !pclk_s && pclk_d_r;
  wire osc_edge   = oscin_s && !oscin_d_r;
  // Clocking stops while powered down
  wire sample_stb = powered && (edge_rise_r ? pclk_rise : pclk_fall);

  // Ten-bit mode masks the upper two bits so their level never reaches the payload
  wire [PIX_W-1:0] data_sel = mode12_r ? px_s.data
                                       : (px_s.data & NARROW_MASK);

  cpg_pixel_s pix_r;
  logic       pix_valid_r;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pix_r       <= '0;
      pix_valid_r <= 1'b0;
    end else if (ce_i) begin
      pix_valid_r <= sample_stb;
      if (sample_stb) begin
        pix_r.data       <= data_sel;
        pix_r.line_sync  <= px_s.line_sync;
        pix_r.frame_sync <= px_s.frame_sync;
      end
    end
  end

  assign pixel_o       = pix_r;
  assign pixel_valid_o = pix_valid_r;

  // Ten-bit sync spacing watch: pixel edges since the last sync change
  logic [CNT_W-1:0] gap_ls_r;
  logic [CNT_W-1:0] gap_fs_r;
  localparam logic [CNT_W-1:0] GAP_LIM = CNT_W'(SYNC_GAP);

  wire ls_chg  = sample_stb && (px_s.line_sync != pix_r.line_sync);
  wire fs_chg  = sample_stb && (px_s.frame_sync != pix_r.frame_sync);
  wire ls_bad  = ls_chg && (gap_ls_r < GAP_LIM);
  wire fs_bad  = fs_chg && (gap_fs_r < GAP_LIM);
  wire viol_set = !mode12_r && (ls_bad || fs_bad);
  wire viol_clr = wr_status && reg_wdata_i[ST_VIOL_BIT];

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || !powered) begin
      gap_ls_r <= GAP_LIM;
      gap_fs_r <= GAP_LIM;
      viol_r   <= 1'b0;
    end else if (ce_i) begin
      if (sample_stb) begin
        gap_ls_r <= ls_chg ? CNT_W'(1) : sat_inc(gap_ls_r, GAP_LIM);
        gap_fs_r <= fs_chg ? CNT_W'(1) : sat_inc(gap_fs_r, GAP_LIM);
      end
      // Set wins over a clear in the same cycle
      viol_r <= viol_set || (viol_r && !viol_clr);
    end
  end

  // Timing source activity: pixel clock or oscillator input
  localparam logic [CNT_W-1:0] ALIVE_LIM = CNT_W'(ALIVE_CYC);
  logic [CNT_W-1:0] idle_r;
  wire src_edge = osc_mode_r ? osc_edge : pclk_rise;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || !powered) begin
      idle_r <= ALIVE_LIM;
    end else if (ce_i) begin
      idle_r <= src_edge ? '0 : sat_inc(idle_r, ALIVE_LIM);
    end
  end

  wire clk_alive = (idle_r < ALIVE_LIM);

  // Oscillator clock output, divided from the system clock
  localparam logic [CNT_W-1:0] DIV_LIM = CNT_W'(OSCILLATOR_CLOCK_OUTPUT_HALF - 1);
  logic [CNT_W-1:0] div_r;
  logic             oscillator_clock_output_r;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || !powered || !osc_mode_r) begin
      div_r    <= '0;
      oscillator_clock_output_r <= 1'b0;
    end else if (ce_i) begin
      if (div_r == DIV_LIM) begin
        div_r    <= '0;
        oscillator_clock_output_r <= !oscillator_clock_output_r;
      end else begin
        div_r <= div_r + 8'h01;
      end
    end
  end

  // Output selection: local bit when the select bit is set, remote level otherwise
  wire [NGPO-1:0] gpo_fwd = (gpo_sel_r & gpo_val_r) | (~gpo_sel_r & remote_pin_i);

  logic [NGPO-1:0] gpo_nxt;
  logic [NGPO-1:0] gpo_oe_nxt;
  logic [NGPO-1:0] gpo_r;
  logic [NGPO-1:0] gpo_oe_r;

  always_comb begin
    gpo_nxt    = gpo_fwd;
    gpo_oe_nxt = {NGPO{1'b1}};
    if (osc_mode_r) begin
      gpo_nxt[GPO_CLK_OUT]    = oscillator_clock_output_r;
      gpo_nxt[GPO_CLK_IN]     = 1'b0;
      gpo_oe_nxt[GPO_CLK_IN]  = 1'b0;
    end
    if (!powered) begin
      gpo_nxt = '0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      gpo_r    <= '0;
      gpo_oe_r <= {NGPO{1'b1}};
    end else if (ce_i) begin
      gpo_r    <= gpo_nxt;
      gpo_oe_r <= gpo_oe_nxt;
    end
  end

  assign forwarded_output_pin_o    = gpo_r;
  assign forwarded_output_pin_oe_o = gpo_oe_r;

  // Register read back, one cycle after the strobe
  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] rdata_r;

  always_comb begin
    rd_mux = '0;
    case (reg_addr_i)
      REG_EDGE:     rd_mux[EDGE_BIT] = edge_rise_r;
      REG_PAYLOAD:  rd_mux[MODE12_BIT] = mode12_r;
      REG_GPO_CTRL: rd_mux = {gpo_val_r, gpo_sel_r};
      REG_STATUS: begin
        rd_mux[ST_OSC_BIT]   = osc_mode_r;
        rd_mux[ST_VIOL_BIT]  = viol_r;
        rd_mux[ST_ALIVE_BIT] = clk_alive;
        rd_mux[ST_PD_BIT]    = !powered;
      end
      REG_PIX_LO:   rd_mux = pix_r.data[DATA_W-1:0];
      REG_PIX_HI: begin
        rd_mux[PIX_W-DATA_W-1:0] = pix_r.data[PIX_W-1:DATA_W];
        rd_mux[HI_LS_BIT]        = pix_r.line_sync;
        rd_mux[HI_FS_BIT]        = pix_r.frame_sync;
      end
      default:      rd_mux = '0;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rdata_r <= '0;
    end else if (ce_i) begin
      rdata_r <= reg_re_i ? rd_mux : '0;
    end
  end

  assign reg_rdata_o = rdata_r;
endmodule
`default_nettype wire

// *** tb/cpg_imager_model.sv ***
// Behavioural image sensor driving the parallel pixel bus
`default_nettype none
module cpg_imager_model
  import cpg_pkg::*;
(
  input  wire logic             sys_clk_i,
  output logic                  pclk_o,
  output logic      [PIX_W-1:0] data_o,
  output logic                  line_sync_o,
  output logic                  frame_sync_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pixel clock stands still low between pixels
  initial begin
    pclk_o = 1'b0;
    data_o = '0;
    line_sync_o = 1'b0;
    frame_sync_o = 1'b0;
  end
  // Data held over both edges so either strobe edge sees the same pixel
  task automatic strobe(input logic [PIX_W-1:0] d, input logic ls, input logic fs, input int hold);
    @(posedge sys_clk_i);
    data_o <= d;
    line_sync_o <= ls;
    frame_sync_o <= fs;
    repeat (hold) @(posedge sys_clk_i);
    pclk_o <= 1'b1;
    repeat (hold) @(posedge sys_clk_i);
    pclk_o <= 1'b0;
    repeat (hold) @(posedge sys_clk_i);
    // Inverse after the hold so a late sample shows up as wrong data
    data_o <= ~d;
  endtask
endmodule
`default_nettype wire

// *** tb/cpg_top_asserts.sv ***
// Port-level checks for the pixel capture and output selection block
`default_nettype none
module cpg_top_asserts
  import cpg_pkg::*;
#(
  parameter int OSCILLATOR_CLOCK_OUTPUT_HALF = 4
) (
  input wire logic             sys_clk_i,
  input wire logic             rst_n_i,
  input wire logic             ce_i,
  input wire logic [7:0]       reg_addr_i,
  input wire logic [7:0]       reg_wdata_i,
  input wire logic             reg_we_i,
  input wire logic             pixel_clk_i,
  input wire logic             power_down_low_active_i,
  input wire logic             osc_mode_strap_i,
  input wire logic [NGPO-1:0]  remote_pin_i,
  input wire logic [NGPO-1:0]  forwarded_output_pin_o,
  input wire logic [NGPO-1:0]  forwarded_output_pin_oe_o,
  input wire cpg_pixel_s       pixel_o,
  input wire logic             pixel_valid_o
);
  logic       edge_r;
  logic       mode_r;
  logic [7:0] ctl_r;
  logic [2:0] settle_r;
  wire        wr_ok = ce_i && reg_we_i;
  wire        ok = (settle_r == 3'h7);
  wire  [3:0] exp_pins = (ctl_r[3:0] & ctl_r[7:4]) | (~ctl_r[3:0] & remote_pin_i);
  // Shadow copies of the control fields; power-down clears them like reset
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || !power_down_low_active_i) begin
      edge_r <= EDGE_RST;
      mode_r <= MODE12_RST;
      ctl_r <= 8'h00;
      settle_r <= 3'h0;
    end else begin
      if (wr_ok && reg_addr_i == REG_EDGE) edge_r <= reg_wdata_i[EDGE_BIT];
      if (wr_ok && reg_addr_i == REG_PAYLOAD) mode_r <= reg_wdata_i[MODE12_BIT];
      if (wr_ok && reg_addr_i == REG_GPO_CTRL) ctl_r <= reg_wdata_i;
      if (!ok) settle_r <= settle_r + 3'h1;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i || !power_down_low_active_i);
  sequence s_pulse;
    pixel_valid_o ##1 !pixel_valid_o;
  endsequence
  property p_gpo_low;
    ok |=> forwarded_output_pin_o[1:0] == $past(exp_pins[1:0]);
  endproperty
  property p_gpo_two;
    ok && !osc_mode_strap_i |=> forwarded_output_pin_o[2] == $past(exp_pins[2]);
  endproperty
  property p_gpo_three;
    ok && !osc_mode_strap_i |=> forwarded_output_pin_o[3] == $past(exp_pins[3])
      && forwarded_output_pin_oe_o[3];
  endproperty
  property p_oscillator_clock_input_oe;
    ok && osc_mode_strap_i |-> !forwarded_output_pin_oe_o[3];
  endproperty
  property p_oscillator_clock_output;
    ok && osc_mode_strap_i && $changed(forwarded_output_pin_o[2])
      |-> ##OSCILLATOR_CLOCK_OUTPUT_HALF $changed(forwarded_output_pin_o[2]);
  endproperty
  property p_sample;
    ok && (edge_r ? $rose(pixel_clk_i) : $fell(pixel_clk_i)) |-> ##[2:4] s_pulse;
  endproperty
  property p_narrow;
    ok && pixel_valid_o && !mode_r |-> pixel_o.data[11:10] == 2'b00;
  endproperty
  property p_pd;
    disable iff (!rst_n_i)
    (!power_down_low_active_i)[*4] |-> forwarded_output_pin_o == '0 && !pixel_valid_o;
  endproperty
  a_gpo_low: assert property (p_gpo_low) else $error("low outputs wrong source");
  a_gpo_two: assert property (p_gpo_two) else $error("output two wrong source");
  a_gpo_three: assert property (p_gpo_three) else $error("output three wrong");
  a_oscillator_clock_input_oe: assert property (p_oscillator_clock_input_oe) else $error("clock input pin driven");
  a_oscillator_clock_output: assert property (p_oscillator_clock_output) else $error("clock output period wrong");
  a_sample: assert property (p_sample) else $error("no sample after edge");
  a_narrow: assert property (p_narrow) else $error("upper bits leak");
  a_pd: assert property (p_pd) else $error("outputs live in power-down");
endmodule
bind cpg_top cpg_top_asserts #(.OSCILLATOR_CLOCK_OUTPUT_HALF(OSCILLATOR_CLOCK_OUTPUT_HALF)) i_asserts (
  .sys_clk_i, .rst_n_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .pixel_clk_i,
  .power_down_low_active_i, .osc_mode_strap_i, .remote_pin_i, .forwarded_output_pin_o,
  .forwarded_output_pin_oe_o, .pixel_o, .pixel_valid_o
);
`default_nettype wire

// *** tb/cpg_top_tb.sv ***
// Self-checking bench for the pixel capture and output selection block
`default_nettype none
module cpg_top_tb;
  import cpg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 3;
  logic             sys_clk_i = 1'b0;
  logic             rst_n_i = 1'b0;
  logic [7:0]       reg_addr_i = '0;
  logic [7:0]       reg_wdata_i = '0;
  logic             reg_we_i = 1'b0;
  logic             reg_re_i = 1'b0;
  logic             power_down_low_active_i = 1'b1;
  logic             osc_mode_strap_i = 1'b0;
  logic             osc = 1'b0;
  logic [NGPO-1:0]  remote_pin_i = '0;
  logic [7:0]       reg_rdata_o;
  logic             pixel_clk_i;
  logic [PIX_W-1:0] pixel_data_i;
  logic             line_sync_i;
  logic             frame_sync_i;
  logic [NGPO-1:0]  forwarded_output_pin_o;
  logic [NGPO-1:0]  forwarded_output_pin_oe_o;
  cpg_pixel_s       pixel_o;
  logic             pixel_valid_o;
  logic [7:0]       ctl [3] = '{8'hA5, 8'h5A, 8'hF0};
  logic [3:0]       e;
  int               t;
  int               errors = 0;
  int               n_compared = 0;
  // Pin 3 carries the oscillator only while the block has released it
  wire              forwarded_output_pin3_i = forwarded_output_pin_oe_o[3] ?
                      forwarded_output_pin_o[3] : osc;
  always #4 sys_clk_i = ~sys_clk_i;
  always #28.5 osc = ~osc;
  cpg_top #(.OSCILLATOR_CLOCK_OUTPUT_HALF(HALF)) i_dut (
    .sys_clk_i, .rst_n_i, .ce_i(1'b1), .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i,
    .reg_rdata_o, .pixel_clk_i, .pixel_data_i, .line_sync_i, .frame_sync_i,
    .power_down_low_active_i, .osc_mode_strap_i, .remote_pin_i, .forwarded_output_pin_o,
    .forwarded_output_pin_oe_o, .forwarded_output_pin3_i, .pixel_o, .pixel_valid_o
  );
  cpg_imager_model i_img (
    .sys_clk_i, .pclk_o(pixel_clk_i), .data_o(pixel_data_i), .line_sync_o(line_sync_i),
    .frame_sync_o(frame_sync_i)
  );
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_we_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_re_i <= 1'b0;
    @(negedge sys_clk_i);
    cmp("read data", {8'h00, exp}, {8'h00, reg_rdata_o});
  endtask
  // Sync pair sy is {frame, line}
  task automatic cap(input logic [11:0] d, input logic [1:0] sy, input logic [11:0] x, input int h);
    int n;
    n = 0;
    fork
      i_img.strobe(d, sy[0], sy[1], h);
      begin
        while (pixel_valid_o !== 1'b1) begin
          @(negedge sys_clk_i);
          n++;
          if (n > 60) begin
            errors++;
            final_report();
          end
        end
        cmp("pixel", {2'b00, sy, x}, {2'b00, pixel_o});
      end
    join
  endtask
  // Sys clocks until the clock output pin next changes, bounded
  task automatic gap(output int n);
    logic p;
    p = forwarded_output_pin_o[2];
    n = 0;
    while (forwarded_output_pin_o[2] === p && n < 20) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (n >= 20) begin
      errors++;
      final_report();
    end
  endtask
  initial begin
    repeat (6) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rd(REG_EDGE, 8'h01);
    rd(REG_PAYLOAD, 8'h00);
    rd(8'h40, 8'h00);
    cap(12'hFFF, 2'b00, 12'h3FF, 3);
    rd(REG_PIX_HI, 8'h03);
    // Syncs held steady in ten-bit mode: no violation, pixel clock seen
    rd(REG_STATUS, 8'h04);
    wr(REG_PAYLOAD, 8'h01);
    cap(12'hA5C, 2'b01, 12'hA5C, 3);
    // Line sync changes on every pixel and frame sync once, legal only in twelve-bit mode
    for (int i = 0; i < 4; i++) cap(12'h800 + 12'(i), 2'(i), 12'h800 + 12'(i), 3);
    wr(REG_EDGE, 8'h00);
    cap(12'h5A3, 2'b10, 12'h5A3, 6);
    foreach (ctl[k]) begin
      remote_pin_i <= ctl[k][7:4] ^ 4'h3;
      e = (ctl[k][3:0] & ctl[k][7:4]) | (~ctl[k][3:0] & (ctl[k][7:4] ^ 4'h3));
      wr(REG_GPO_CTRL, ctl[k]);
      repeat (2) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      cmp("pins", {8'h00, 4'hF, e}, {8'h00, forwarded_output_pin_oe_o, forwarded_output_pin_o});
    end
    @(posedge sys_clk_i);
    power_down_low_active_i <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    power_down_low_active_i <= 1'b1;
    @(negedge sys_clk_i);
    cmp("pins", 16'h0000, {12'h000, forwarded_output_pin_o});
    repeat (4) @(posedge sys_clk_i);
    rd(REG_EDGE, 8'h01);
    rd(REG_PAYLOAD, 8'h00);
    rd(REG_GPO_CTRL, 8'h00);
    // Line sync changes one pixel apart in ten-bit mode: the watch must flag it
    cap(12'h001, 2'b01, 12'h001, 3);
    cap(12'h002, 2'b00, 12'h002, 3);
    rd(REG_STATUS, 8'h06);
    wr(REG_STATUS, 8'h02);
    rd(REG_STATUS, 8'h04);
    @(posedge sys_clk_i);
    osc_mode_strap_i <= 1'b1;
    rst_n_i <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (40) @(posedge sys_clk_i);
    rd(REG_STATUS, 8'h05);
    cmp("pin3 enable", 16'h0000, {15'h0000, forwarded_output_pin_oe_o[3]});
    gap(t);
    gap(t);
    cmp("clock half period", 16'(HALF), 16'(t));
    final_report();
  end
endmodule
`default_nettype wire
